// [uart_pkg.sv]
package uart_pkg;
  localparam logic [7:0] ADDR_CTRL_A = 8'hc0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hc1;
  localparam logic [7:0] ADDR_CTRL_C = 8'hc2;
  localparam logic [7:0] ADDR_BAUD_L = 8'hc4;
  localparam logic [7:0] ADDR_BAUD_H = 8'hc5;
  localparam logic [7:0] ADDR_DATA = 8'hc6;
  localparam logic [7:0] CTRL_C_RESET = 8'h06;
  localparam int RX_DONE_IE_BIT = 7;
  localparam int TX_DONE_IE_BIT = 6;
  localparam int BUF_EMPTY_IE_BIT = 5;
  localparam int RX_EN_BIT = 4;
  localparam int TX_EN_BIT = 3;
  localparam int SIZE_TOP_BIT = 2;
  localparam int TX_NINTH_BIT = 0;
  localparam int TX_DONE_FLAG_BIT = 6;
  localparam int DOUBLE_SPEED_BIT = 1;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] PARITY_ODD = 2'h3;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] RATIO_NORMAL = 4'hf;
  localparam logic [3:0] RATIO_DOUBLE = 4'h7;
  localparam logic [3:0] MID_NORMAL = 4'h7;
  localparam logic [3:0] MID_DOUBLE = 4'h3;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b011,
    TX_PAR = 3'b010,
    TX_STOP = 3'b110
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_PAR = 3'b010,
    RX_STOP = 3'b110
  } rx_state_t;
  // Data bit count from the size code; reserved codes fall back to eight
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    if (code == SIZE_NINE) begin
      data_bits = 4'h9;
    end else if (code[2]) begin
      data_bits = 4'h8;
    end else begin
      data_bits = {2'h0, code[1:0]} + 4'h5;
    end
  endfunction
endpackage

// [rx_fifo_if.sv]
`timescale 1ns/1ps
// Two-entry receive buffer connection
interface rx_fifo_if;
  logic push;
  logic pop;
  logic flush;
  logic [11:0] wdata;
  logic [11:0] rdata;
  logic empty;
  logic full;
  modport owner (output push, output pop, output flush, output wdata, input rdata, input empty, input full);
  modport store (input push, input pop, input flush, input wdata, output rdata, output empty, output full);
endinterface

// [rx_fifo.sv]
`timescale 1ns/1ps
// Two-level receive buffer; entry holds {frame err, parity err, overrun, nine data bits}
module rx_fifo (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Buffer port
  rx_fifo_if.store fif
);
  logic [11:0] mem_ff [2];
  logic [11:0] nxt_mem [2];
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [11:0] rd_ff;
  logic [11:0] nxt_rd;

  // Shift-down storage: head always in slot 0
  always_comb begin
    nxt_mem = mem_ff;
    nxt_cnt = cnt_ff;
    if (fif.flush) begin
      nxt_cnt = 2'h0;
    end else begin
      if (fif.pop && cnt_ff != 2'h0) begin
        nxt_mem[0] = mem_ff[1];
        nxt_cnt = cnt_ff - 2'h1;
      end
      if (fif.push && nxt_cnt != 2'h2) begin
        nxt_mem[nxt_cnt[0]] = fif.wdata;
        nxt_cnt = nxt_cnt + 2'h1;
      end
    end
    nxt_rd = (nxt_cnt == 2'h0) ? 12'h000 : nxt_mem[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ff[0] <= 12'h000;
      mem_ff[1] <= 12'h000;
      cnt_ff <= 2'h0;
      rd_ff <= 12'h000;
    end else begin
      mem_ff <= nxt_mem;
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
    end
  end

  assign fif.rdata = rd_ff;
  assign fif.empty = (cnt_ff == 2'h0);
  assign fif.full = (cnt_ff == 2'h2);
endmodule // rx_fifo

// [uart_ctrl.sv]
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module uart_ctrl (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor global interrupt flag
  input wire logic global_irq_en,
  // Interrupt requests
  output logic rx_done_irq,
  output logic tx_done_irq,
  output logic buf_empty_irq,
  // Serial pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic rx_pin_owned
);
  logic [7:0] ctrl_b_ff, nxt_ctrl_b;
  logic [7:0] ctrl_c_ff, nxt_ctrl_c;
  logic [7:0] baud_l_ff, nxt_baud_l;
  logic [3:0] baud_h_ff, nxt_baud_h;
  logic dbl_ff, nxt_dbl;
  logic tx_done_ff, nxt_tx_done;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [8:0] txbuf_ff, nxt_txbuf;
  logic txbuf_full_ff, nxt_txbuf_full;
  // Baud prescaler and tick
  logic [11:0] pre_ff, nxt_pre;
  logic tick;
  // Transmitter
  uart_pkg::tx_state_t tx_st_ff, nxt_tx_st;
  logic [8:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] tx_sub_ff, nxt_tx_sub;
  logic tx_par_ff, nxt_tx_par;
  logic tx_active_ff, nxt_tx_active;
  logic txd_ff, nxt_txd;
  // Receiver
  uart_pkg::rx_state_t rx_st_ff, nxt_rx_st;
  logic [8:0] rx_sh_ff, nxt_rx_sh;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt;
  logic [3:0] rx_sub_ff, nxt_rx_sub;
  logic rx_par_ff, nxt_rx_par;
  logic rx_perr_ff, nxt_rx_perr;
  logic ovr_ff, nxt_ovr;
  logic [1:0] sync_ff;
  logic rxd;
  // Output registers, then access decodes and frame settings
  logic irq_rx_ff, irq_tx_ff, irq_be_ff;
  logic oe_ff, rxown_ff;
  logic acc, wr, rd;
  logic [2:0] size_code;
  logic [3:0] nbits;
  logic [3:0] ratio;
  logic [3:0] mid;
  logic par_on;
  logic stop2;
  rx_fifo_if fif ();

  rx_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .fif(fif)
  );

  assign acc = psel && penable && pready_ff;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign size_code = {ctrl_b_ff[uart_pkg::SIZE_TOP_BIT], ctrl_c_ff[2:1]};
  assign nbits = uart_pkg::data_bits(size_code);
  assign par_on = ctrl_c_ff[5];
  assign stop2 = ctrl_c_ff[3];
  assign ratio = dbl_ff ? uart_pkg::RATIO_DOUBLE : uart_pkg::RATIO_NORMAL;
  assign mid = dbl_ff ? uart_pkg::MID_DOUBLE : uart_pkg::MID_NORMAL;
  assign rxd = sync_ff[1];

  // Two-flop synchroniser for the serial input; resets high, then follows the pin whether the receiver is on or off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff <= 2'b11;
    end else begin
      sync_ff <= {sync_ff[0], serial_in_pin};
    end
  end

  // Register file, APB answer, prescaler, transmitter, receiver
  always_comb begin
    nxt_ctrl_b = ctrl_b_ff;
    nxt_ctrl_c = ctrl_c_ff;
    nxt_baud_l = baud_l_ff;
    nxt_baud_h = baud_h_ff;
    nxt_dbl = dbl_ff;
    nxt_tx_done = tx_done_ff;
    nxt_txbuf = txbuf_ff;
    nxt_txbuf_full = txbuf_full_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_pre = pre_ff;
    tick = 1'b0;
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_sub = tx_sub_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tx_active = tx_active_ff;
    nxt_txd = txd_ff;
    nxt_rx_st = rx_st_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_sub = rx_sub_ff;
    nxt_rx_par = rx_par_ff;
    nxt_rx_perr = rx_perr_ff;
    nxt_ovr = ovr_ff;
    fif.push = 1'b0;
    fif.pop = 1'b0;
    fif.flush = 1'b0;
    fif.wdata = {1'b0, rx_perr_ff, ovr_ff, rx_sh_ff};
    // One wait state: pready rises in the second access cycle
    if (psel && penable && !pready_ff) begin
      nxt_pready = 1'b1;
      if (!pwrite) begin
        if (paddr == uart_pkg::ADDR_CTRL_A) begin
          nxt_prdata = {24'h00_0000, !fif.empty, tx_done_ff, !txbuf_full_ff, fif.rdata[11],
                        fif.rdata[9], fif.rdata[10], dbl_ff, 1'b0};
        end else if (paddr == uart_pkg::ADDR_CTRL_B) begin
          nxt_prdata = {24'h00_0000, ctrl_b_ff[7:2], fif.rdata[8], ctrl_b_ff[0]};
        end else if (paddr == uart_pkg::ADDR_CTRL_C) begin
          nxt_prdata = {24'h00_0000, 2'b00, ctrl_c_ff[5:1], 1'b0};
        end else if (paddr == uart_pkg::ADDR_BAUD_L) begin
          nxt_prdata = {24'h00_0000, baud_l_ff};
        end else if (paddr == uart_pkg::ADDR_BAUD_H) begin
          nxt_prdata = {28'h000_0000, baud_h_ff};
        end else if (paddr == uart_pkg::ADDR_DATA) begin
          nxt_prdata = {24'h00_0000, fif.rdata[7:0]};
        end else begin
          nxt_prdata = 32'h0000_0000;
          nxt_pslverr = 1'b1;
        end
      end else if (!(paddr == uart_pkg::ADDR_CTRL_A || paddr == uart_pkg::ADDR_CTRL_B ||
                     paddr == uart_pkg::ADDR_CTRL_C || paddr == uart_pkg::ADDR_BAUD_L ||
                     paddr == uart_pkg::ADDR_BAUD_H || paddr == uart_pkg::ADDR_DATA)) begin
        // Refused writes answer with zero data, like refused reads
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b1;
      end
    end
    // Prescaler counts down; a low-baud write reloads it at once
    if (pre_ff == 12'h000) begin
      nxt_pre = {baud_h_ff, baud_l_ff};
      tick = 1'b1;
    end else begin
      nxt_pre = pre_ff - 12'h001;
    end
    if (wr) begin
      if (paddr == uart_pkg::ADDR_CTRL_A) begin
        nxt_dbl = pwdata[uart_pkg::DOUBLE_SPEED_BIT];
        if (pwdata[uart_pkg::TX_DONE_FLAG_BIT]) begin
          nxt_tx_done = 1'b0;
        end
      end else if (paddr == uart_pkg::ADDR_CTRL_B) begin
        nxt_ctrl_b = {pwdata[7:2], 1'b0, pwdata[0]};
      end else if (paddr == uart_pkg::ADDR_CTRL_C) begin
        nxt_ctrl_c = {2'b00, pwdata[5:1], 1'b0};
      end else if (paddr == uart_pkg::ADDR_BAUD_L) begin
        nxt_baud_l = pwdata[7:0];
        nxt_pre = {baud_h_ff, pwdata[7:0]};
      end else if (paddr == uart_pkg::ADDR_BAUD_H) begin
        nxt_baud_h = pwdata[3:0];
      end else if (paddr == uart_pkg::ADDR_DATA && !txbuf_full_ff) begin
        // Ninth bit latched from the control bit written beforehand
        nxt_txbuf = {ctrl_b_ff[uart_pkg::TX_NINTH_BIT], pwdata[7:0]};
        nxt_txbuf_full = 1'b1;
      end
    end
    if (rd && paddr == uart_pkg::ADDR_DATA) begin
      fif.pop = 1'b1;
    end
    // Transmitter: stays active after enable drops until everything is sent
    nxt_tx_active = ctrl_b_ff[uart_pkg::TX_EN_BIT] || tx_st_ff != uart_pkg::TX_IDLE || txbuf_full_ff;
    if (!tx_active_ff) begin
      nxt_txbuf_full = 1'b0;
    end
    if (tick) begin
      if (tx_st_ff == uart_pkg::TX_IDLE) begin
        if (txbuf_full_ff && tx_active_ff) begin
          nxt_tx_sh = txbuf_ff;
          nxt_txbuf_full = 1'b0;
          nxt_tx_st = uart_pkg::TX_START;
          nxt_tx_sub = ratio;
          nxt_txd = 1'b0;
          nxt_tx_par = (ctrl_c_ff[4:0] >> 4) == 5'h1;
        end
      end else if (tx_sub_ff != 4'h0) begin
        nxt_tx_sub = tx_sub_ff - 4'h1;
      end else begin
        nxt_tx_sub = ratio;
        case (tx_st_ff)
          uart_pkg::TX_START: begin
            nxt_tx_st = uart_pkg::TX_DATA;
            nxt_tx_cnt = nbits - 4'h1;
            nxt_txd = tx_sh_ff[0];
            nxt_tx_par = tx_par_ff ^ tx_sh_ff[0];
            nxt_tx_sh = {1'b0, tx_sh_ff[8:1]};
          end
          uart_pkg::TX_DATA: begin
            if (tx_cnt_ff != 4'h0) begin
              nxt_tx_cnt = tx_cnt_ff - 4'h1;
              nxt_txd = tx_sh_ff[0];
              nxt_tx_par = tx_par_ff ^ tx_sh_ff[0];
              nxt_tx_sh = {1'b0, tx_sh_ff[8:1]};
            end else if (par_on) begin
              nxt_tx_st = uart_pkg::TX_PAR;
              nxt_txd = tx_par_ff;
            end else begin
              nxt_tx_st = uart_pkg::TX_STOP;
              nxt_tx_cnt = stop2 ? 4'h1 : 4'h0;
              nxt_txd = 1'b1;
            end
          end
          uart_pkg::TX_PAR: begin
            nxt_tx_st = uart_pkg::TX_STOP;
            nxt_tx_cnt = stop2 ? 4'h1 : 4'h0;
            nxt_txd = 1'b1;
          end
          uart_pkg::TX_STOP: begin
            if (tx_cnt_ff != 4'h0) begin
              nxt_tx_cnt = tx_cnt_ff - 4'h1;
            end else begin
              nxt_tx_st = uart_pkg::TX_IDLE;
              if (!txbuf_full_ff) begin
                nxt_tx_done = 1'b1;
              end
            end
          end
          default: nxt_tx_st = uart_pkg::TX_IDLE;
        endcase
      end
    end
    // Receiver samples the middle of each bit at the divided rate
    if (!ctrl_b_ff[uart_pkg::RX_EN_BIT]) begin
      fif.flush = 1'b1;
      nxt_rx_st = uart_pkg::RX_IDLE;
      nxt_ovr = 1'b0;
    end else if (tick) begin
      case (rx_st_ff)
        uart_pkg::RX_IDLE: begin
          if (!rxd) begin
            nxt_rx_st = uart_pkg::RX_START;
            nxt_rx_sub = mid;
          end
        end
        default: begin
          if (rx_sub_ff != 4'h0) begin
            nxt_rx_sub = rx_sub_ff - 4'h1;
          end else begin
            nxt_rx_sub = ratio;
            case (rx_st_ff)
              uart_pkg::RX_START: begin
                if (rxd) begin
                  nxt_rx_st = uart_pkg::RX_IDLE;
                end else begin
                  nxt_rx_st = uart_pkg::RX_DATA;
                  nxt_rx_cnt = nbits;
                  nxt_rx_sh = 9'h000;
                  nxt_rx_par = ctrl_c_ff[4];
                  nxt_ovr = fif.full;
                end
              end
              uart_pkg::RX_DATA: begin
                nxt_rx_sh = rx_sh_ff | ({8'h00, rxd} << (nbits - rx_cnt_ff));
                nxt_rx_par = rx_par_ff ^ rxd;
                nxt_rx_cnt = rx_cnt_ff - 4'h1;
                if (rx_cnt_ff == 4'h1) begin
                  nxt_rx_st = par_on ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
                  nxt_rx_perr = 1'b0;
                end
              end
              uart_pkg::RX_PAR: begin
                nxt_rx_perr = rx_par_ff ^ rxd;
                nxt_rx_st = uart_pkg::RX_STOP;
              end
              uart_pkg::RX_STOP: begin
                // Receiver checks one stop bit only, whatever the stop select
                nxt_rx_st = uart_pkg::RX_IDLE;
                fif.wdata = {!rxd, rx_perr_ff, ovr_ff, rx_sh_ff};
                fif.push = !fif.full;
              end
              default: nxt_rx_st = uart_pkg::RX_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // All state registers except the input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_ff <= 8'h00;
      ctrl_c_ff <= uart_pkg::CTRL_C_RESET;
      baud_l_ff <= 8'h00;
      baud_h_ff <= 4'h0;
      dbl_ff <= 1'b0;
      tx_done_ff <= 1'b0;
      txbuf_ff <= 9'h000;
      txbuf_full_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      pre_ff <= 12'h000;
      tx_st_ff <= uart_pkg::TX_IDLE;
      tx_sh_ff <= 9'h000;
      tx_cnt_ff <= 4'h0;
      tx_sub_ff <= 4'h0;
      tx_par_ff <= 1'b0;
      tx_active_ff <= 1'b0;
      txd_ff <= 1'b1;
      rx_st_ff <= uart_pkg::RX_IDLE;
      rx_sh_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
      rx_sub_ff <= 4'h0;
      rx_par_ff <= 1'b0;
      rx_perr_ff <= 1'b0;
      ovr_ff <= 1'b0;
      irq_rx_ff <= 1'b0;
      irq_tx_ff <= 1'b0;
      irq_be_ff <= 1'b0;
      oe_ff <= 1'b0;
      rxown_ff <= 1'b0;
    end else begin
      ctrl_b_ff <= nxt_ctrl_b;
      ctrl_c_ff <= nxt_ctrl_c;
      baud_l_ff <= nxt_baud_l;
      baud_h_ff <= nxt_baud_h;
      dbl_ff <= nxt_dbl;
      tx_done_ff <= nxt_tx_done;
      txbuf_ff <= nxt_txbuf;
      txbuf_full_ff <= nxt_txbuf_full;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      pre_ff <= nxt_pre;
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_sub_ff <= nxt_tx_sub;
      tx_par_ff <= nxt_tx_par;
      tx_active_ff <= nxt_tx_active;
      txd_ff <= nxt_txd;
      rx_st_ff <= nxt_rx_st;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_sub_ff <= nxt_rx_sub;
      rx_par_ff <= nxt_rx_par;
      rx_perr_ff <= nxt_rx_perr;
      ovr_ff <= nxt_ovr;
      irq_rx_ff <= ctrl_b_ff[uart_pkg::RX_DONE_IE_BIT] && global_irq_en && !fif.empty;
      irq_tx_ff <= ctrl_b_ff[uart_pkg::TX_DONE_IE_BIT] && global_irq_en && tx_done_ff;
      irq_be_ff <= ctrl_b_ff[uart_pkg::BUF_EMPTY_IE_BIT] && global_irq_en && !txbuf_full_ff;
      oe_ff <= nxt_tx_active;
      rxown_ff <= ctrl_b_ff[uart_pkg::RX_EN_BIT];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign rx_done_irq = irq_rx_ff;
  assign tx_done_irq = irq_tx_ff;
  assign buf_empty_irq = irq_be_ff;
  assign serial_out_pin = txd_ff;
  assign serial_out_oe = oe_ff;
  assign rx_pin_owned = rxown_ff;
endmodule // uart_ctrl

// [uart_ctrl_checker.sv]
`timescale 1ns/1ps
module uart_ctrl_checker (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt side
  input wire logic global_irq_en,
  input wire logic rx_done_irq,
  input wire logic tx_done_irq,
  input wire logic buf_empty_irq,
  // Serial side
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic rx_pin_owned
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Setup cycle, then the first access cycle
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  // Shortest start bit: ratio eight with divisor zero
  sequence s_start_bit;
    !serial_out_pin [*8];
  endsequence
  property p_ready_wait;
    s_access |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("access not answered after one wait state");
  property p_refused_zero;
    pready && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_refused_zero: assert property (p_refused_zero) else $error("refused access returned data");
  // Requests lag their cause one cycle, so the global flag is seen one cycle back
  property p_rx_irq;
    rx_done_irq |-> $past(global_irq_en);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive request without global flag");
  property p_tx_irq;
    tx_done_irq |-> $past(global_irq_en);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit request without global flag");
  property p_empty_irq;
    buf_empty_irq |-> $past(global_irq_en);
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("empty request without global flag");
  // A receiver held off keeps its buffer flushed
  property p_rx_flush;
    !rx_pin_owned [*4] |-> !rx_done_irq;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("data kept while receiver off");
  property p_tx_idle;
    !serial_out_oe |-> serial_out_pin;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("line driven low without pin ownership");
  // Pin goes back only at idle level, never in mid-frame
  property p_tx_release;
    $fell(serial_out_oe) |-> $past(serial_out_pin);
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("pin released in mid-frame");
  property p_start_len;
    $fell(serial_out_pin) |-> s_start_bit;
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit shorter than eight clocks");
endmodule // uart_ctrl_checker

bind uart_ctrl uart_ctrl_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .global_irq_en, .rx_done_irq, .tx_done_irq, .buf_empty_irq, .serial_in_pin,
  .serial_out_pin, .serial_out_oe, .rx_pin_owned);

// [serial_peer.sv]
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic pclk,
  // Line from the device transmitter
  input wire logic tx_line,
  // Line into the device receiver
  output logic rx_line
);
  int bt = 32;
  int frames = 0;
  int low_len = 0;
  logic [12:0] got;
  // Idle line is high between frames
  initial rx_line = 1'h1;
  // Samples bit centres after each start edge; back-to-back frames are not realigned
  always begin
    @(negedge tx_line);
    repeat (bt / 2) @(posedge pclk);
    for (int i = 0; i < 13; i++) begin
      repeat (bt) @(posedge pclk);
      got[i] = tx_line;
    end
    frames++;
  end
  // Low run after a start edge; waits out the frame so data lows do not overwrite it
  always begin
    @(negedge tx_line);
    low_len = 0;
    while (tx_line === 1'h0) begin
      @(posedge pclk);
      #1;
      low_len++;
    end
    @(frames);
  end
  // Start bit, data LSB first, optional parity, then stop and idle high
  task automatic send(input logic [8:0] d, input int n, input logic p, input logic pen);
    logic [12:0] f;
    f = 13'h1fff;
    for (int i = 0; i < n; i++) f[i] = d[i];
    if (pen) f[n] = p;
    @(posedge pclk);
    rx_line <= 1'h0;
    for (int i = 0; i < 13; i++) begin
      repeat (bt) @(posedge pclk);
      rx_line <= f[i];
    end
  endtask
endmodule // serial_peer

// [tb.sv]
`timescale 1ns/1ps
module tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic global_irq_en = 1'h0;
  logic rx_done_irq;
  logic tx_done_irq;
  logic buf_empty_irq;
  logic serial_in_pin;
  logic serial_out_pin;
  logic serial_out_oe;
  logic rx_pin_owned;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int comparisons = 0;
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  uart_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .global_irq_en, .rx_done_irq, .tx_done_irq, .buf_empty_irq, .serial_in_pin, .serial_out_pin,
    .serial_out_oe, .rx_pin_owned);
  serial_peer peer (.pclk, .tx_line(serial_out_pin), .rx_line(serial_in_pin));
  // Counts each compare and reports a difference at once
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    check("pready", 32'(pready), 32'h0000_0001);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    apb(1'h0, a, 8'h00);
    check(what, rd, {24'h00_0000, exp});
  endtask
  // Waits for the peer to finish capturing a frame
  task automatic wait_frame(input int k);
    int n;
    n = 0;
    while (peer.frames < k && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    check("frames", peer.frames, k);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 4000 clocks
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    $display("[ERR] watchdog expired");
    end_of_test();
  end
  initial begin
    logic [2:0] code;
    logic [1:0] pm;
    logic [8:0] d;
    logic [12:0] f;
    int n;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    rchk("ctrl_b", uart_pkg::ADDR_CTRL_B, 8'h00);
    rchk("ctrl_c", uart_pkg::ADDR_CTRL_C, uart_pkg::CTRL_C_RESET);
    rchk("baud_low", uart_pkg::ADDR_BAUD_L, 8'h00);
    rchk("baud_high", uart_pkg::ADDR_BAUD_H, 8'h00);
    rchk("status", uart_pkg::ADDR_CTRL_A, 8'h20);
    rchk("hole", 8'hc3, 8'h00);
    check("hole err", 32'(err), 32'h0000_0001);
    wr(uart_pkg::ADDR_BAUD_H, 8'h0f);
    rchk("baud_high", uart_pkg::ADDR_BAUD_H, 8'h0f);
    wr(uart_pkg::ADDR_BAUD_H, 8'h00);
    wr(uart_pkg::ADDR_BAUD_L, 8'h01);
    $display("test registers done");
    // Size codes 0 to 3 and 7 with every parity mode, one stop, 32 clocks a bit
    for (int i = 0; i < 5; i++) begin
      code = (i == 4) ? 3'h7 : 3'(i);
      pm = (i == 4) ? 2'h3 : 2'(i);
      n = code[2] ? 9 : 32'(code) + 5;
      d = 9'h1a5 & ((9'h001 << n) - 9'h001);
      f = 13'h1fff;
      for (int j = 0; j < n; j++) f[j] = d[j];
      if (pm[1]) f[n] = ^d ^ pm[0];
      wr(uart_pkg::ADDR_CTRL_C, {2'h0, pm, 1'h0, code[1:0], 1'h0});
      wr(uart_pkg::ADDR_CTRL_B, {4'h0, 1'h1, code[2], 1'h0, d[8]});
      wr(uart_pkg::ADDR_DATA, d[7:0]);
      wait_frame(i + 1);
      check("tx frame", 32'(peer.got), 32'(f));
      check("bit time", peer.low_len, 32);
    end
    check("oe", 32'(serial_out_oe), 32'h0000_0001);
    $display("test frames done");
    // Two stops, a second character queued, enable dropped while busy
    wr(uart_pkg::ADDR_CTRL_C, 8'h2e);
    wr(uart_pkg::ADDR_DATA, 8'ha5);
    n = 0;
    do begin
      apb(1'h0, uart_pkg::ADDR_CTRL_A, 8'h00);
      n++;
    end while (rd[5] !== 1'h1 && n < 50);
    wr(uart_pkg::ADDR_DATA, 8'h5a);
    wr(uart_pkg::ADDR_CTRL_B, 8'h04);
    check("oe held", 32'(serial_out_oe), 32'h0000_0001);
    wait_frame(6);
    // Nine bits kept: parity, two stops, then the queued start bit
    check("stop bits", 32'(peer.got[12:9]), 32'h0000_0007);
    n = 0;
    while (serial_out_oe !== 1'h0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    check("drained", 32'(n > 300), 32'h0000_0001);
    check("oe released", 32'(serial_out_oe), 32'h0000_0000);
    rchk("status", uart_pkg::ADDR_CTRL_A, 8'h60);
    // Requests gated by the global flag, then the transmit done request cleared by writing one
    wr(uart_pkg::ADDR_CTRL_B, 8'h60);
    repeat (3) @(posedge pclk);
    check("irq off", {29'h0, rx_done_irq, tx_done_irq, buf_empty_irq}, 32'h0000_0000);
    global_irq_en <= 1'h1;
    repeat (3) @(posedge pclk);
    check("irq on", {29'h0, rx_done_irq, tx_done_irq, buf_empty_irq}, 32'h0000_0003);
    wr(uart_pkg::ADDR_CTRL_A, 8'h40);
    repeat (3) @(posedge pclk);
    check("irq clr", {29'h0, rx_done_irq, tx_done_irq, buf_empty_irq}, 32'h0000_0001);
    $display("test interrupts done");
    // Nine-bit odd parity at double speed, 16 clocks a bit
    wr(uart_pkg::ADDR_CTRL_A, 8'h02);
    peer.bt = 16;
    wr(uart_pkg::ADDR_CTRL_C, 8'h36);
    wr(uart_pkg::ADDR_CTRL_B, 8'h94);
    repeat (3) @(posedge pclk);
    check("rx owned", 32'(rx_pin_owned), 32'h0000_0001);
    peer.send(9'h13c, 9, 1'h1, 1'h1);
    check("rx irq", 32'(rx_done_irq), 32'h0000_0001);
    rchk("status", uart_pkg::ADDR_CTRL_A, 8'ha6);
    rchk("ninth", uart_pkg::ADDR_CTRL_B, 8'h96);
    rchk("data", uart_pkg::ADDR_DATA, 8'h3c);
    rchk("status", uart_pkg::ADDR_CTRL_A, 8'h22);
    peer.send(9'h055, 9, 1'h1, 1'h1);
    rchk("status", uart_pkg::ADDR_CTRL_A, 8'ha2);
    wr(uart_pkg::ADDR_CTRL_B, 8'h84);
    repeat (4) @(posedge pclk);
    check("rx freed", 32'({rx_pin_owned, rx_done_irq}), 32'h0000_0000);
    rchk("status", uart_pkg::ADDR_CTRL_A, 8'h22);
    $display("test receive done");
    end_of_test();
  end
endmodule // tb
